// ---- rtl/rft_pkg.sv ----
// shared constants of the reader frontend timer unit
package rft_pkg;
	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] RFT_IDX_MODE = 8'h2a;
	localparam logic [7:0] RFT_IDX_PRESCALE = 8'h2b;
	localparam logic [7:0] RFT_IDX_RELOAD_HIGH = 8'h2c;
	localparam logic [7:0] RFT_IDX_RELOAD_LOW = 8'h2d;
	localparam logic [7:0] RFT_IDX_COUNT_HIGH = 8'h2e;
	localparam logic [7:0] RFT_IDX_COUNT_LOW = 8'h2f;
	localparam logic [7:0] RFT_IDX_CONFIG = 8'h38;
	localparam logic [7:0] RFT_IDX_STATUS = 8'h39;
	localparam logic [7:0] RFT_IDX_CONTROL = 8'h3a;

	// mode register fields
	localparam int RFT_MODE_AUTO_BIT = 7;
	localparam int RFT_MODE_GATE_LSB = 5;
	localparam int RFT_MODE_RESTART_BIT = 4;
	localparam int RFT_MODE_PRE_HI_LSB = 0;

	// config register fields
	localparam int RFT_CFG_EVEN_BIT = 0;
	localparam int RFT_CFG_MULTI_BIT = 1;
	localparam int RFT_CFG_106K_BIT = 2;

	// status register fields
	localparam int RFT_STAT_RUN_BIT = 0;
	localparam int RFT_STAT_FLAG_BIT = 1;

	// control register fields, write-only strobes
	localparam int RFT_CTL_START_BIT = 0;
	localparam int RFT_CTL_STOP_BIT = 1;

	// reset values
	localparam logic [7:0] RFT_RST_MODE = 8'h00;
	localparam logic [7:0] RFT_RST_PRESCALE = 8'h00;
	localparam logic [7:0] RFT_RST_RELOAD = 8'h00;
	localparam logic [7:0] RFT_RST_CONFIG = 8'h00;
	localparam logic [15:0] RFT_RST_COUNT = 16'h0000;

	// received bits after which an automatic stop happens
	localparam logic [2:0] RFT_STOP_BITS_106K = 3'h5;
	localparam logic [2:0] RFT_STOP_BITS_OTHER = 3'h4;

	// gating selections
	typedef enum logic [1:0] {
		RFT_GATE_NONE = 2'h0,
		RFT_GATE_EXT = 2'h1,
		RFT_GATE_AUX = 2'h2,
		RFT_GATE_UNUSED = 2'h3
	} rft_gate_t;

	// bus slave phases
	typedef enum logic [0:0] {
		RFT_BUS_IDLE,
		RFT_BUS_DATA
	} rft_bus_t;
endpackage

// ---- rtl/rft_prescaler.sv ----
// prescaler producing the timer tick from the reference strobe
`timescale 1ns/1ps
module rft_prescaler
	import rft_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic restart,
	input wire logic ref_strobe,
	input wire logic enable,
	input wire logic [11:0] prescale,
	input wire logic even_divider_select,
	output logic tick
);
	logic [12:0] div_count_reg;
	logic [12:0] div_count_next;
	logic tick_reg;
	logic tick_next;
	logic [12:0] last_count;

	// last count is divisor minus one: 2p for odd, 2p+1 for even
	always_comb begin
		last_count = {prescale, even_divider_select};
		div_count_next = div_count_reg;
		tick_next = 1'b0;
		if (restart) begin
			div_count_next = 13'h0000;
		end else if (enable && ref_strobe) begin
			if (div_count_reg >= last_count) begin
				div_count_next = 13'h0000;
				tick_next = 1'b1;
			end else begin
				div_count_next = div_count_reg + 13'h0001;
			end
		end
	end

	// the divider pauses, not clears, while gated off
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_count_reg <= 13'h0000;
			tick_reg <= 1'b0;
		end else begin
			div_count_reg <= div_count_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// ---- rtl/rft_timer.sv ----
// reader frontend timer unit with its ahb-lite register slave
//
// Contract
// - prescaler is the 4-bit high nibble joined above the 8-bit low byte
// - with even select clear, tick rate is reference over 2p+1
// - even select resets to zero; when set, tick rate is ref over 2p+2
// - reload upper byte is its own read-write register, reset zero
// - reload lower byte is its own read-write register, reset zero
// - every start event copies the reload value into the counter
// - reload writes never disturb a running count
// - upper counter byte is readable, read only
// - lower counter byte is readable, read only
// - auto start after transmit; stop after fifth or fourth received bit
// - restart reloads at end; otherwise stop at zero and raise flag
// - auto start with multi receive ignores received bits; stops on stop request or expiry
`timescale 1ns/1ps
module rft_timer
	import rft_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic ref_strobe,
	input wire logic transmit_done,
	input wire logic rx_bit_strobe,
	input wire logic external_gate_input,
	input wire logic first_auxiliary_pin,
	output logic timer_running,
	output logic timer_expiry_flag
);
	// bus state
	rft_bus_t bus_state_reg;
	rft_bus_t bus_state_next;
	logic [7:0] addr_idx_reg;
	logic [7:0] addr_idx_next;
	logic addr_ok_reg;
	logic addr_ok_next;
	logic write_reg;
	logic write_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;
	logic hreadyout_reg;
	logic hreadyout_next;

	// software-visible state
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [7:0] prescale_low_byte_reg;
	logic [7:0] prescale_low_byte_next;
	logic [7:0] reload_value_upper_reg;
	logic [7:0] reload_value_upper_next;
	logic [7:0] reload_value_lower_reg;
	logic [7:0] reload_value_lower_next;
	logic [7:0] config_reg;
	logic [7:0] config_next;

	// timer state
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic running_reg;
	logic running_next;
	logic flag_reg;
	logic flag_next;
	logic [2:0] rx_bits_reg;
	logic [2:0] rx_bits_next;

	// pin synchronisers
	logic ext_meta_reg;
	logic ext_sync_reg;
	logic aux_meta_reg;
	logic aux_sync_reg;

	// decoded strobes and helpers
	logic wr_en;
	logic [7:0] wr_byte;
	logic start_ev;
	logic stop_ev;
	logic auto_stop;
	logic gate_open;
	logic tick;
	logic [11:0] prescale;
	logic [2:0] stop_bits;
	logic [7:0] rd_byte;
	rft_gate_t gate_sel;

	// fields pulled out of the mode and config bytes
	assign prescale = {mode_reg[RFT_MODE_PRE_HI_LSB +: 4],
		prescale_low_byte_reg};
	assign gate_sel = rft_gate_t'(mode_reg[RFT_MODE_GATE_LSB +: 2]);
	assign stop_bits = config_reg[RFT_CFG_106K_BIT] ?
		RFT_STOP_BITS_106K : RFT_STOP_BITS_OTHER;

	// two flops on each pin before any logic looks at it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			aux_meta_reg <= 1'b0;
			aux_sync_reg <= 1'b0;
		end else begin
			ext_meta_reg <= external_gate_input;
			ext_sync_reg <= ext_meta_reg;
			aux_meta_reg <= first_auxiliary_pin;
			aux_sync_reg <= aux_meta_reg;
		end
	end

	// gate high lets ticks through; the unused code behaves as ungated
	always_comb begin
		case (gate_sel)
			RFT_GATE_NONE: gate_open = 1'b1;
			RFT_GATE_EXT: gate_open = ext_sync_reg;
			RFT_GATE_AUX: gate_open = aux_sync_reg;
			RFT_GATE_UNUSED: gate_open = 1'b1;
			default: gate_open = 1'b1;
		endcase
	end

	rft_prescaler u_prescaler (
		.clk(clk),
		.reset(reset),
		.restart(start_ev),
		.ref_strobe(ref_strobe),
		.enable(running_reg && gate_open),
		.prescale(prescale),
		.even_divider_select(config_reg[RFT_CFG_EVEN_BIT]),
		.tick(tick)
	);

	// read mux; counter bytes come straight from the live count
	always_comb begin
		case (addr_idx_reg)
			RFT_IDX_MODE: rd_byte = mode_reg;
			RFT_IDX_PRESCALE: rd_byte = prescale_low_byte_reg;
			RFT_IDX_RELOAD_HIGH: rd_byte = reload_value_upper_reg;
			RFT_IDX_RELOAD_LOW: rd_byte = reload_value_lower_reg;
			RFT_IDX_COUNT_HIGH: rd_byte = count_reg[15:8];
			RFT_IDX_COUNT_LOW: rd_byte = count_reg[7:0];
			RFT_IDX_CONFIG: rd_byte = config_reg;
			RFT_IDX_STATUS: rd_byte = {6'h00, flag_reg, running_reg};
			default: rd_byte = 8'h00;
		endcase
		if (!addr_ok_reg) begin
			rd_byte = 8'h00;
		end
	end

	// ahb-lite slave: one wait state so read data leaves a flop
	always_comb begin
		bus_state_next = bus_state_reg;
		addr_idx_next = addr_idx_reg;
		addr_ok_next = addr_ok_reg;
		write_next = write_reg;
		hrdata_next = hrdata_reg;
		hreadyout_next = 1'b1;
		wr_en = 1'b0;
		wr_byte = hwdata[7:0];
		case (bus_state_reg)
			RFT_BUS_IDLE: begin
				if (hsel && htrans[1] && hready) begin
					bus_state_next = RFT_BUS_DATA;
					addr_idx_next = haddr[9:2];
					addr_ok_next = (haddr[31:10] == 22'h00_0000) &&
						(haddr[1:0] == 2'h0);
					write_next = hwrite;
					hreadyout_next = 1'b0;
				end
			end
			RFT_BUS_DATA: begin
				bus_state_next = RFT_BUS_IDLE;
				wr_en = write_reg && addr_ok_reg;
				hrdata_next = write_reg ? 32'h0000_0000 :
					{24'h00_0000, rd_byte};
			end
			default: begin
				bus_state_next = RFT_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus_state_reg <= RFT_BUS_IDLE;
			addr_idx_reg <= 8'h00;
			addr_ok_reg <= 1'b0;
			write_reg <= 1'b0;
			hrdata_reg <= 32'h0000_0000;
			hreadyout_reg <= 1'b1;
		end else begin
			bus_state_reg <= bus_state_next;
			addr_idx_reg <= addr_idx_next;
			addr_ok_reg <= addr_ok_next;
			write_reg <= write_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= hreadyout_next;
		end
	end

	// start and stop events; a start in the same cycle wins over a stop
	always_comb begin
		start_ev = (wr_en && addr_idx_reg == RFT_IDX_CONTROL &&
			wr_byte[RFT_CTL_START_BIT]) ||
			(mode_reg[RFT_MODE_AUTO_BIT] && transmit_done);
		auto_stop = mode_reg[RFT_MODE_AUTO_BIT] &&
			!config_reg[RFT_CFG_MULTI_BIT] && running_reg &&
			rx_bit_strobe &&
			(rx_bits_reg + 3'h1 == stop_bits);
		stop_ev = auto_stop || (wr_en && addr_idx_reg == RFT_IDX_CONTROL &&
			wr_byte[RFT_CTL_STOP_BIT]);
	end

	// register writes and the counter itself
	always_comb begin
		mode_next = mode_reg;
		prescale_low_byte_next = prescale_low_byte_reg;
		reload_value_upper_next = reload_value_upper_reg;
		reload_value_lower_next = reload_value_lower_reg;
		config_next = config_reg;
		count_next = count_reg;
		running_next = running_reg;
		flag_next = flag_reg;
		rx_bits_next = rx_bits_reg;
		if (wr_en) begin
			case (addr_idx_reg)
				RFT_IDX_MODE: mode_next = wr_byte;
				RFT_IDX_PRESCALE: prescale_low_byte_next = wr_byte;
				// reload bytes only hold the value; the count is untouched
				RFT_IDX_RELOAD_HIGH: reload_value_upper_next = wr_byte;
				RFT_IDX_RELOAD_LOW: reload_value_lower_next = wr_byte;
				RFT_IDX_CONFIG: config_next = {5'h00, wr_byte[2:0]};
				RFT_IDX_STATUS: begin
					if (wr_byte[RFT_STAT_FLAG_BIT]) begin
						flag_next = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (transmit_done) begin
			rx_bits_next = 3'h0;
		end else if (rx_bit_strobe && running_reg &&
			rx_bits_reg != 3'h7) begin
			rx_bits_next = rx_bits_reg + 3'h1;
		end
		// expiry is judged on the tick that finds the counter at zero
		if (running_reg && tick) begin
			if (count_reg == 16'h0000) begin
				if (mode_reg[RFT_MODE_RESTART_BIT]) begin
					count_next = {reload_value_upper_reg,
						reload_value_lower_reg};
				end else begin
					running_next = 1'b0;
					flag_next = 1'b1;
				end
			end else begin
				count_next = count_reg - 16'h0001;
			end
		end
		if (stop_ev) begin
			running_next = 1'b0;
		end
		if (start_ev) begin
			count_next = {reload_value_upper_reg,
				reload_value_lower_reg};
			running_next = 1'b1;
		end
	end

	// counter bytes read live, so a borrow may fall between two reads
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg <= RFT_RST_MODE;
			prescale_low_byte_reg <= RFT_RST_PRESCALE;
			reload_value_upper_reg <= RFT_RST_RELOAD;
			reload_value_lower_reg <= RFT_RST_RELOAD;
			config_reg <= RFT_RST_CONFIG;
			count_reg <= RFT_RST_COUNT;
			running_reg <= 1'b0;
			flag_reg <= 1'b0;
			rx_bits_reg <= 3'h0;
		end else begin
			mode_reg <= mode_next;
			prescale_low_byte_reg <= prescale_low_byte_next;
			reload_value_upper_reg <= reload_value_upper_next;
			reload_value_lower_reg <= reload_value_lower_next;
			config_reg <= config_next;
			count_reg <= count_next;
			running_reg <= running_next;
			flag_reg <= flag_next;
			rx_bits_reg <= rx_bits_next;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign timer_running = running_reg;
	assign timer_expiry_flag = flag_reg;
endmodule

// ---- tb/rft_timer_asserts.sv ----
// port checker for the reader frontend timer unit
`timescale 1ns/1ps
module rft_timer_asserts(
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic ref_strobe,
	input wire logic transmit_done,
	input wire logic rx_bit_strobe,
	input wire logic timer_running,
	input wire logic timer_expiry_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// transfer accepted at this edge; hready is the slave's own ready
	wire logic take = hsel && htrans[1] && hready && hreadyout;
	// bus answers with exactly one wait state, always okay, one byte wide
	property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
	a_wait: assert property (p_wait) else $error("wait state");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad resp");
	property p_byte; hrdata[31:8] == 24'h00_0000; endproperty
	a_byte: assert property (p_byte) else $error("upper data");
	// running only starts on a transmit end or a register write
	property p_start;
		$rose(timer_running) |-> $past(transmit_done) || !$past(hreadyout);
	endproperty
	a_start: assert property (p_start) else $error("start");
	// a stop needs expiry, a received bit or a register write
	property p_stop;
		$fell(timer_running) |-> timer_expiry_flag || $past(rx_bit_strobe)
			|| !$past(hreadyout);
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	// expiry stops the count and follows a strobe by two clocks
	property p_flag; $rose(timer_expiry_flag) |-> $fell(timer_running);
	endproperty
	a_flag: assert property (p_flag) else $error("flag");
	property p_tick; $rose(timer_expiry_flag) |-> $past(ref_strobe, 2);
	endproperty
	a_tick: assert property (p_tick) else $error("tick");
	property p_clear; $fell(timer_expiry_flag) |-> !$past(hreadyout);
	endproperty
	a_clear: assert property (p_clear) else $error("clear");
endmodule
bind rft_timer rft_timer_asserts chk_u(.clk, .reset, .hsel, .htrans,
	.hready, .hrdata, .hreadyout, .hresp, .ref_strobe, .transmit_done,
	.rx_bit_strobe, .timer_running, .timer_expiry_flag);

// ---- tb/rft_timer_tb.sv ----
// self-checking bench for the reader frontend timer unit
`timescale 1ns/1ps
module rft_timer_tb;
	logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rv;
	logic [1:0] htrans = 2'h0, ph = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, timer_running, timer_expiry_flag, stb_en = 1'b0;
	logic ref_strobe = 1'b0, transmit_done = 1'b0, rx_bit_strobe = 1'b0;
	logic external_gate_input = 1'b0, first_auxiliary_pin = 1'b0;
	logic [7:0] cfgs [3] = '{8'h00, 8'h04, 8'h02};
	logic [11:0] pre;
	int bad_count = 0, n_checks = 0, nstb = 0, seed = 47674, n0, i, k;
	rft_timer dut_u(
		.clk(clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ref_strobe(ref_strobe),
		.transmit_done(transmit_done),
		.rx_bit_strobe(rx_bit_strobe),
		.external_gate_input(external_gate_input),
		.first_auxiliary_pin(first_auxiliary_pin),
		.timer_running(timer_running),
		.timer_expiry_flag(timer_expiry_flag)
	);
	always #2 clk = ~clk;
	// strobe every third clock; strobes seen while running are counted
	always @(posedge clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		ref_strobe <= stb_en && ph == 2'h2;
		if (ref_strobe && timer_running)
			nstb <= nstb + 1;
	end
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one word transfer; each phase held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, a, 2'h0};
		do @(posedge clk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (!hreadyout);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, d);
		bus(1'b1, a, d);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	// counter bytes back to back; strobes are off so no borrow between
	task automatic rdcnt(input logic [15:0] exp);
		rdx(8'h2e, {24'h0, exp[15:8]});
		rdx(8'h2f, {24'h0, exp[7:0]});
		rdx(8'h2e, {24'h0, exp[15:8]});
	endtask
	// strobes from start to expiry: reload plus one ticks of one divisor each
	function automatic int exp_strobes(input int r, p, ev);
		return (r + 1) * (2 * p + 1 + ev);
	endfunction
	// strobes on until n more are counted or the timer stops
	task automatic run(input int n);
		int t;
		t = nstb + n;
		stb_en <= 1'b1;
		for (int j = 0; j < 60000 && nstb < t && timer_running; j++)
			@(posedge clk);
		stb_en <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic pulse(input logic rx);
		if (rx)
			rx_bit_strobe <= 1'b1;
		else
			transmit_done <= 1'b1;
		@(posedge clk);
		rx_bit_strobe <= 1'b0;
		transmit_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		#300000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// reset values, refused writes to count and an unmapped place
		wr(8'h30, 8'hff);
		wr(8'h2e, 8'hff);
		for (i = 8'h2a; i < 8'h31; i++)
			rdx(i[7:0], 32'h0);
		rdx(8'h38, 32'h0);
		repeat (4) begin
			rv = $random(seed);
			wr(8'h2c, rv[15:8]);
			wr(8'h2d, rv[7:0]);
			rdx(8'h2c, {24'h0, rv[15:8]});
			rdx(8'h2d, {24'h0, rv[7:0]});
		end
		$display("register test done");
		// odd and even divisors, 12-bit prescale, expiry raises the flag
		for (i = 0; i < 6; i++) begin
			rv = $random(seed);
			pre = (i < 2) ? 12'h0 : {3'h0, i == 5, 3'h0, rv[4:0]};
			wr(8'h2a, {4'h0, pre[11:8]});
			wr(8'h2b, pre[7:0]);
			wr(8'h38, {7'h0, i[0]});
			wr(8'h2c, 8'h00);
			wr(8'h2d, {5'h0, rv[10:8]});
			n0 = nstb;
			wr(8'h3a, 8'h01);
			run(1000000);
			k = exp_strobes(rv[10:8], pre, i[0]);
			chk(nstb - n0, k);
			chk(timer_expiry_flag, 1'b1);
			wr(8'h39, 8'h02);
			chk(timer_expiry_flag, 1'b0);
		end
		$display("divider test done");
		// each gate pin; reload writes leave the running count alone
		external_gate_input <= 1'b1;
		first_auxiliary_pin <= 1'b1;
		rv = $random(seed);
		rv[8] = 1'b1;
		wr(8'h2a, 8'h20);
		wr(8'h38, 8'h00);
		// divisor of one, so each strobe is one tick in the counts below
		wr(8'h2b, 8'h00);
		wr(8'h2c, rv[15:8]);
		wr(8'h2d, rv[7:0]);
		wr(8'h3a, 8'h01);
		wr(8'h2c, ~rv[15:8]);
		wr(8'h2d, ~rv[7:0]);
		rdcnt(rv[15:0]);
		for (i = 1; i < 3; i++) begin
			wr(8'h2a, {1'h0, i[1:0], 5'h0});
			run(3);
			rv = rv - 32'h3;
			rdcnt(rv[15:0]);
			if (i == 1)
				external_gate_input <= 1'b0;
			else
				first_auxiliary_pin <= 1'b0;
			repeat (4) @(posedge clk);
			run(2);
			rdcnt(rv[15:0]);
		end
		wr(8'h3a, 8'h02);
		chk(timer_running, 1'b0);
		// auto restart reloads at expiry and keeps counting
		wr(8'h2a, 8'h10);
		wr(8'h2c, 8'h00);
		wr(8'h2d, 8'h02);
		wr(8'h3a, 8'h01);
		run(4);
		rdcnt(16'h1);
		chk({timer_running, timer_expiry_flag}, 2'h2);
		wr(8'h3a, 8'h02);
		$display("gating test done");
		// start after transmit; stop after 4 or 5 bits, or only on request
		wr(8'h2a, 8'h80);
		for (i = 0; i < 3; i++) begin
			wr(8'h38, cfgs[i]);
			pulse(1'b0);
			chk(timer_running, 1'b1);
			for (k = 1; k < 7; k++) begin
				pulse(1'b1);
				chk(timer_running, cfgs[i][1] || k < 4 + cfgs[i][2]);
			end
			wr(8'h3a, 8'h02);
			chk(timer_running, 1'b0);
		end
		$display("auto start test done");
		close_out();
	end
endmodule
